/* File: src/sop_serial_port.sv */
// Operation
// - Word clock is an input only in slave, right-justify, delay-select mode.
// - Word-clock-input mode places each 16-bit word where the host chooses.
// - MSB is driven in the period after word clock is sampled high.
// - Word clock high at field start gives MSB on second sampling edge.
// - Word placement may differ in every field, left and right alike.
// - Master right-justified delayed mode pulses word clock in cycle 17 only.
// - In that mode the MSB is valid on the 18th sampling edge.
// - In that mode the LSB runs into the next field's first period.
// - Master bit clock transmit edges launch from reference clock rising edges.
// - Master channel and word clock edges launch from transmit edges.
// - Master data and tag change only after a transmit edge.
// - Slave data and tag follow channel clock changes and transmit edges.
// - Reset is active low and asynchronous; host holds it minimum width.
// - Edge select high: change on falling, sample on rising; low reverses.
// - Two's complement, MSB first, left channel before right.
// - Master right-justified mode frames the word from cycle 17.
// - Next sample loads in the last eighth; host reads right MSB earlier.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sop_defs.svh"

module sop_serial_port
  import sop_pkg::*;
#(
  parameter int unsigned BCLK_HALF = `SOP_BCLK_HALF_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        bit_clock_i,
  output var  logic        bit_clock_o,
  output var  logic        bit_clock_oe_o,
  input  wire logic        channel_select_clock_i,
  output var  logic        channel_select_clock_o,
  output var  logic        channel_select_clock_oe_o,
  input  wire logic        word_clock_i,
  output var  logic        word_clock_o,
  output var  logic        word_clock_oe_o,
  output var  logic        serial_data_output_o,
  output var  logic        tag_output_o
);

  // ==========================================================
  // Declarations
  sop_mode_t   mode_q;
  logic [31:0] data_q;
  logic [31:0] act_q;
  logic [2:0]  s1_q, s2_q, s3_q;
  logic [15:0] div_q;
  logic        bclk_q, m_tx_q, m_smp_q;
  logic [5:0]  idx_q;
  logic        chan_q, lr_q, wclk_q, done_q;
  sop_word_t   word_q;
  logic [15:0] sh_q;
  logic [3:0]  bits_q;
  logic        sdo_q, tag_q;
  logic        clk_oe_q, wclk_oe_q;
  logic        pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // ==========================================================
  // Mode decode
  wire slave   = mode_q.slave;
  wire rl      = mode_q.right_left_justify_select;
  wire fbd     = mode_q.first_bit_delay_select;
  wire tx_lvl  = ~mode_q.edge_polarity_select;          // level after a transmit edge
  wire wc_in   = slave & rl & fbd;
  wire rjd     = rl & fbd & ~slave;

  // ==========================================================
  // Input synchronisers: bit 0 bit clock, 1 channel clock, 2 word clock
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {word_clock_i, channel_select_clock_i, bit_clock_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Slave edge events, taken only from the second stage onward
  wire s_bedge = s2_q[0] ^ s3_q[0];
  wire s_tx    = s_bedge & (s2_q[0] == tx_lvl);
  wire s_smp   = s_bedge & (s2_q[0] != tx_lvl);
  wire s_lr    = slave & (s2_q[1] ^ s3_q[1]);

  // ==========================================================
  // Master bit clock divider
  wire div_end = (div_q == 16'(BCLK_HALF - 1));
  wire m_tx    = ~slave & div_end & (~bclk_q == tx_lvl);
  wire m_smp   = ~slave & div_end & (~bclk_q != tx_lvl);

  // Bit clock toggles on a reference rising edge; the frame logic acts a cycle later
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q   <= 16'h0000;
      bclk_q  <= 1'b0;
      m_tx_q  <= 1'b0;
      m_smp_q <= 1'b0;
    end else begin
      div_q   <= (slave | div_end) ? 16'h0000 : 16'(div_q + 16'h0001);
      bclk_q  <= slave ? tx_lvl : (bclk_q ^ div_end);
      m_tx_q  <= m_tx;
      m_smp_q <= m_smp;
    end
  end

  // ==========================================================
  // Frame position and word placement
  wire       tx_ev  = slave ? s_tx  : m_tx_q;
  wire       smp_ev = slave ? s_smp : m_smp_q;
  wire       step   = tx_ev | s_lr;
  // Slave count saturates so a gated or slow bit clock never restarts a word
  wire [5:0] nidx   = s_lr ? 6'h00 :
                      (slave & (idx_q == `SOP_IDX_MAX)) ? idx_q : 6'(idx_q + 6'h01);
  wire [5:0] npos   = slave ? nidx : {1'b0, nidx[4:0]};
  wire       chan_n = slave ? (s_lr ? s2_q[1] : chan_q) : ~nidx[5];
  wire [5:0] st_pos = rl ? (fbd ? `SOP_POS_RJD : `SOP_POS_RJ)
                         : (fbd ? `SOP_POS_I2S : `SOP_POS_LJ);
  wire [5:0] end_pos = 6'(st_pos + `SOP_WORD_BITS);
  // Delayed right-justified mode only marks the cycle before the MSB
  wire       wclk_n = rjd ? (npos == `SOP_POS_RJ)
                          : ((npos >= st_pos) & (npos < end_pos));
  wire       fix_ld = step & ~wc_in & (npos == st_pos) & (word_q != SOP_SHIFT);
  wire       wc_ld  = tx_ev & wc_in & (word_q == SOP_ARMED);
  wire       load   = fix_ld | wc_ld;
  wire       arm    = smp_ev & wc_in & s2_q[2] & ~done_q & (word_q == SOP_IDLE);
  wire [15:0] word  = chan_n ? act_q[15:0] : act_q[31:16];
  wire       tag_n  = chan_n ? mode_q.tag_l : mode_q.tag_r;
  wire       stage  = tx_ev & ~chan_n & (npos == `SOP_POS_LOAD);

  // Position counter, channel and framing clocks
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_q  <= 6'h00;
      chan_q <= 1'b1;
      lr_q   <= 1'b1;
      wclk_q <= 1'b0;
      done_q <= 1'b0;
    end else if (step) begin
      idx_q  <= nidx;
      chan_q <= chan_n;
      lr_q   <= slave ? lr_q : chan_n;
      wclk_q <= wclk_n;
      done_q <= s_lr ? 1'b0 : (done_q | arm);
    end else begin
      done_q <= done_q | arm;
    end
  end

  // Output word shifter; an armed word waits for the next transmit edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_q <= SOP_IDLE;
      sh_q   <= 16'h0000;
      bits_q <= 4'h0;
      sdo_q  <= 1'b0;
      tag_q  <= 1'b0;
    end else begin
      case (word_q)
        SOP_IDLE: begin
          if (load) begin
            word_q <= SOP_SHIFT;
          end else if (arm) begin
            word_q <= SOP_ARMED;
          end
        end
        SOP_ARMED: begin
          if (load) begin
            word_q <= SOP_SHIFT;
          end
        end
        SOP_SHIFT: begin
          if (tx_ev & (bits_q == 4'h0) & ~load) begin
            word_q <= SOP_IDLE;
          end
        end
        default: begin
          word_q <= SOP_IDLE;
        end
      endcase
      if (load) begin
        sh_q   <= {word[14:0], 1'b0};
        bits_q <= 4'hF;
        sdo_q  <= word[15];
        tag_q  <= tag_n;
      end else if (tx_ev & (word_q == SOP_SHIFT)) begin
        sh_q   <= {sh_q[14:0], 1'b0};
        bits_q <= 4'(bits_q - 4'h1);
        sdo_q  <= (bits_q == 4'h0) ? 1'b0 : sh_q[15];
        tag_q  <= (bits_q == 4'h0) ? 1'b0 : tag_q;
      end
    end
  end

  // ==========================================================
  // Sample staging and pin direction
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_q     <= `SOP_DATA_RST;
      clk_oe_q  <= 1'b0;
      wclk_oe_q <= 1'b0;
    end else begin
      act_q     <= stage ? data_q : act_q;
      clk_oe_q  <= ~slave;
      wclk_oe_q <= ~wc_in;
    end
  end

  // ==========================================================
  // APB slave, zero wait states, error on unmapped address
  wire        setup  = psel_i & ~penable_i;
  wire        acc    = psel_i & penable_i & pready_q;
  wire        hit_c  = (paddr_i == `SOP_CTRL_OFF);
  wire        hit_d  = (paddr_i == `SOP_DATA_OFF);
  wire        hit_s  = (paddr_i == `SOP_STAT_OFF);
  wire [31:0] stat_w = {22'h000000, word_q, chan_q, wclk_q, idx_q};
  wire [31:0] rd_mux = hit_c ? {26'h0000000, mode_q} :
                       hit_d ? data_q : hit_s ? stat_w : 32'h0000_0000;

  // Read data is captured in setup so it comes straight from a flop
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      mode_q    <= `SOP_CTRL_RST;
      data_q    <= `SOP_DATA_RST;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~(hit_c | hit_d | hit_s);
      prdata_q  <= setup ? rd_mux : prdata_q;
      mode_q    <= (acc & pwrite_i & hit_c) ? sop_mode_t'(pwdata_i[5:0]) : mode_q;
      data_q    <= (acc & pwrite_i & hit_d) ? pwdata_i : data_q;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_o                  = prdata_q;
  assign pready_o                  = pready_q;
  assign pslverr_o                 = pslverr_q;
  assign bit_clock_o               = bclk_q;
  assign bit_clock_oe_o            = clk_oe_q;
  assign channel_select_clock_o    = lr_q;
  assign channel_select_clock_oe_o = clk_oe_q;
  assign word_clock_o              = wclk_q;
  assign word_clock_oe_o           = wclk_oe_q;
  assign serial_data_output_o      = sdo_q;
  assign tag_output_o              = tag_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Assertion helpers
  // Age of the delayed right-justified mode; a word begun in an earlier mode
  // may still drain for half a field, so those checks wait until it has gone
  logic [7:0] rjd_age_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rjd_age_q <= 8'h00;
    end else if (!rjd) begin
      rjd_age_q <= 8'h00;
    end else if (rjd_age_q != 8'hFF) begin
      rjd_age_q <= 8'(rjd_age_q + 8'h01);
    end
  end

  wire rjd_settled = rjd & (rjd_age_q == 8'hFF);   // Old words have drained

  // Direction flops lag the mode by one cycle, and by one more out of reset
  wclk_dir_a: assert property ($past(rst_n_i) && $stable(mode_q)
      |-> word_clock_oe_o == !wc_in)
    else $error("word clock direction wrong for mode");
  bclk_dir_a: assert property ($past(rst_n_i) && $stable(mode_q)
      |-> bit_clock_oe_o == !slave && channel_select_clock_oe_o == !slave)
    else $error("bit clock direction wrong for mode");
  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  err_rdy_a: assert property (pslverr_o |-> pready_o)
    else $error("error flagged without ready");
  tag_idle_a: assert property (word_q != SOP_SHIFT |-> !tag_output_o)
    else $error("tag high outside word");
  lr_edge_a: assert property (!slave && $changed(channel_select_clock_o)
      |-> idx_q[4:0] == 5'h00)
    else $error("channel clock change off field boundary");
  wclk_arm_a: assert property (word_q == SOP_ARMED && tx_ev |=>
      word_q == SOP_SHIFT && bits_q == 4'hF)
    else $error("armed word not started at transmit edge");
  pulse_rise_a: assert property (rjd_settled && $rose(word_clock_o)
      |-> idx_q[4:0] == 5'h10)
    else $error("word clock pulse not in cycle 17");
  pulse_fall_a: assert property (rjd_settled && $fell(word_clock_o)
      |-> idx_q[4:0] == 5'h11)
    else $error("word clock pulse longer than one bit");
  msb_pos_a: assert property (rjd_settled && word_q == SOP_SHIFT && bits_q == 4'hF
      |-> idx_q[4:0] == 5'h11)
    else $error("delayed MSB not at 18th edge");
  lsb_wrap_a: assert property (rjd_settled && word_q == SOP_SHIFT && bits_q == 4'h0
      |-> idx_q[4:0] == 5'h00)
    else $error("LSB not in first period of next field");
  bclk_launch_a: assert property (!slave && $changed(bit_clock_o) |-> $past(div_end))
    else $error("bit clock edge off divider");
  // A polarity write lands between the divider decode and the step, so the
  // launch checks skip the two cycles that follow a control write that changes the mode
  lr_launch_a: assert property (!slave && mode_q == $past(mode_q, 2)
      && $changed(channel_select_clock_o)
      |-> $past(m_tx_q) && bit_clock_o == tx_lvl)
    else $error("channel clock not launched from transmit edge");
  data_launch_a: assert property (!slave && mode_q == $past(mode_q, 2)
      && $changed(serial_data_output_o)
      |-> $past(m_tx_q) && bit_clock_o == tx_lvl)
    else $error("master data changed off transmit edge");
  slave_upd_a: assert property (slave && $stable(mode_q) && $changed(serial_data_output_o)
      |-> $past(s_tx || s_lr))
    else $error("slave data changed without clock event");
  idle_low_a: assert property (word_q != SOP_SHIFT |-> !serial_data_output_o)
    else $error("data high outside word");

endmodule

`default_nettype wire

/* File: src/sop_defs.svh */
`ifndef SOP_DEFS_SVH
`define SOP_DEFS_SVH

// ==========================================================
// Register map (byte addresses on the APB)
`define SOP_CTRL_OFF       12'h000
`define SOP_DATA_OFF       12'h004
`define SOP_STAT_OFF       12'h008

// ==========================================================
// Control register fields and reset value
`define SOP_CTRL_SLAVE     0
`define SOP_CTRL_RLJ       1
`define SOP_CTRL_FBD       2
`define SOP_CTRL_EPS       3
`define SOP_CTRL_TAGL      4
`define SOP_CTRL_TAGR      5
`define SOP_CTRL_W         6
`define SOP_CTRL_RST       6'h00
`define SOP_DATA_RST       32'h0000_0000

// ==========================================================
// Word placement inside a 32-bit field (bit-clock period index)
`define SOP_WORD_BITS      6'h10
`define SOP_POS_LJ         6'h00
`define SOP_POS_I2S        6'h01
`define SOP_POS_RJ         6'h10
`define SOP_POS_RJD        6'h11
`define SOP_POS_LOAD       6'h18
`define SOP_IDX_MAX        6'h3F

// ==========================================================
// Timing: reference clock and generated bit clock
`define SOP_CLK_PERIOD_NS  50
`define SOP_BCLK_PERIOD_NS 400
`define SOP_BCLK_HALF_CYC  (`SOP_BCLK_PERIOD_NS / (2 * `SOP_CLK_PERIOD_NS))

`endif

/* File: src/sop_pkg.sv */
package sop_pkg;

  // Port configuration as held in the control register
  typedef struct packed {
    logic tag_r;
    logic tag_l;
    logic edge_polarity_select;
    logic first_bit_delay_select;
    logic right_left_justify_select;
    logic slave;
  } sop_mode_t;

  // Output word progress, Gray coded along idle -> armed -> shift
  typedef enum logic [1:0] {
    SOP_IDLE  = 2'b00,
    SOP_ARMED = 2'b01,
    SOP_SHIFT = 2'b11
  } sop_word_t;

endpackage

/* File: sim/sop_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host receiver: makes slave clocks, captures 64-bit frames
module sop_host_model (
  input  wire logic        bck_i,
  input  wire logic        lr_i,
  input  wire logic        data_i,
  input  wire logic        tag_i,
  input  wire logic        wck_i,
  input  wire logic        eps_i,
  input  wire logic        wmode_i,
  input  wire logic [5:0]  pl_i,
  input  wire logic [5:0]  pr_i,
  output var  logic        bck_o,
  output var  logic        lr_o,
  output var  logic        wck_o,
  output var  logic [63:0] data_f_o,
  output var  logic [63:0] tag_f_o,
  output var  logic [63:0] wck_f_o,
  output var  int          frames_o
);
  logic [63:0] d_q, t_q, w_q;
  int          k, idx;

  // One free-running source derives all link clocks, 64 bits a frame
  initial begin
    bck_o = 1'b0;
    lr_o = 1'b1;
    wck_o = 1'b0;
    k = 0;
    idx = 0;
    frames_o = 0;
    d_q = '0;
    t_q = '0;
    w_q = '0;
    #13;
    forever begin
      #200 bck_o = ~bck_o;
      if (bck_o !== eps_i) begin
        k = (k + 1) % 64;
        lr_o = (k < 32);
        // High one period ahead of the MSB slot chosen for this field
        wck_o = wmode_i && ((k % 32) + 1 == int'(k < 32 ? pl_i : pr_i));
      end
    end
  end

  // New left field: publish the finished frame, restart the index
  always @(lr_i) begin
    if (lr_i === 1'b1) begin
      data_f_o = d_q;
      tag_f_o = t_q;
      wck_f_o = w_q;
      frames_o++;
    end
    idx = (lr_i === 1'b1) ? 0 : 32;
  end

  // Capture on the sampling edge picked by edge polarity
  always @(bck_i) begin
    if (bck_i === eps_i) begin
      d_q[idx] = data_i;
      t_q[idx] = tag_i;
      w_q[idx] = wck_i;
      if (idx < 63) idx++;
    end
  end
endmodule

`default_nettype wire

/* File: sim/tb_stereo_adc_serial_output_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sop_defs.svh"

module tb_stereo_adc_serial_output_port;
  import sop_pkg::*;
  // Rows: slave, justify, delay, polarity, left slot, right slot
  localparam logic [15:0] ROWS [0:8] = '{16'h0000, 16'h3041, 16'h4410, 16'h7451,
    16'h9000, 16'hA041, 16'hD410, 16'hE401, 16'hF250};
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rng;
  logic        bck_o, bck_oe, lr_o, lr_oe, wck_o, wck_oe, sdo, tag;
  logic        host_bck, host_lr, host_wck, eps_m, wmode_m;
  logic [5:0]  pl, pr;
  logic [63:0] f_d, f_t, f_w;
  int          frames, n_errors, checked, cycles;
  wire logic   bck_pin, lr_pin, wck_pin;

  // Pin levels follow whichever side has its driver enabled
  assign bck_pin = bck_oe ? bck_o : host_bck;
  assign lr_pin = lr_oe ? lr_o : host_lr;
  assign wck_pin = wck_oe ? wck_o : host_wck;

  sop_serial_port dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .bit_clock_i(bck_pin), .bit_clock_o(bck_o),
    .bit_clock_oe_o(bck_oe), .channel_select_clock_i(lr_pin),
    .channel_select_clock_o(lr_o), .channel_select_clock_oe_o(lr_oe),
    .word_clock_i(wck_pin), .word_clock_o(wck_o), .word_clock_oe_o(wck_oe),
    .serial_data_output_o(sdo), .tag_output_o(tag)
  );

  sop_host_model host (
    .bck_i(bck_pin), .lr_i(lr_pin), .data_i(sdo), .tag_i(tag), .wck_i(wck_pin),
    .eps_i(eps_m), .wmode_i(wmode_m), .pl_i(pl), .pr_i(pr), .bck_o(host_bck),
    .lr_o(host_lr), .wck_o(host_wck), .data_f_o(f_d), .tag_f_o(f_t), .wck_f_o(f_w),
    .frames_o(frames)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Expected frame: 16 bits MSB first from each slot, zeros elsewhere
  function automatic logic [63:0] place(input logic [15:0] l, input logic [15:0] r,
                                        input int sl, input int sr);
    logic [63:0] f;
    f = '0;
    for (int i = 0; i < 16; i++) begin
      f[(sl + i) % 64] = l[15 - i];
      f[(32 + sr + i) % 64] = r[15 - i];
    end
    return f;
  endfunction

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // APB master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence: every port mode, then an asynchronous reset
  initial begin
    logic [31:0] rd, smp;
    logic        err, wm;
    logic [15:0] row;
    sop_mode_t   m;
    int          f0;
    {rst_n, psel, penable, pwrite, eps_m, wmode_m} = '0;
    {paddr, pwdata, pl, pr} = '0;
    {n_errors, checked, cycles} = '0;
    rng = 32'h4201283E;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SOP_CTRL_OFF, 32'h0, rd, err);
    chk("ctrl reset", rd, `SOP_CTRL_RST);
    apb(1'b0, `SOP_DATA_OFF, 32'h0, rd, err);
    chk("data reset", rd, `SOP_DATA_RST);
    apb(1'b0, 12'h00C, 32'h0, rd, err);
    chk("unmapped read", {err, rd}, 33'h100000000);
    for (int r = 0; r < 9; r++) begin
      row = ROWS[r];
      smp = xs();
      m = sop_mode_t'({rng[9:8], row[12], row[13], row[14], row[15]});
      wm = row[15] & row[14] & row[13];
      eps_m <= row[12];
      wmode_m <= wm;
      pl <= row[11:6];
      pr <= row[5:0];
      apb(1'b1, `SOP_CTRL_OFF, {26'h0, m}, rd, err);
      apb(1'b1, `SOP_DATA_OFF, smp, rd, err);
      apb(1'b0, `SOP_DATA_OFF, 32'h0, rd, err);
      chk("data readback", rd, smp);
      f0 = frames;
      wait (frames >= f0 + 4);
      @(posedge clk);
      chk("word clock oe", wck_oe, !wm);
      chk("bit clock oe", {bck_oe, lr_oe}, {2{!row[15]}});
      chk("data", f_d, place(smp[15:0], smp[31:16], pl, pr));
      chk("tag", f_t, place({16{m.tag_l}}, {16{m.tag_r}}, pl, pr));
      if (!wm) chk("word clock", f_w, (row[15:13] == 3'b011) ? 64'h0001000000010000
        : place(16'hFFFF, 16'hFFFF, pl, pr));
    end
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk("reset outputs", {sdo, lr_o, bck_oe, lr_oe, wck_oe}, 5'b01000);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SOP_CTRL_OFF, 32'h0, rd, err);
    chk("ctrl after reset", rd, `SOP_CTRL_RST);
    summarize();
  end
endmodule

`default_nettype wire
